// ### src/lpddr_read_pkg.sv
// What this block does
// - read carries column, bank, auto-precharge flag
// - auto precharge closes row after burst
// - auto precharge starts burst/2 cycles after read
// - first element after latency, then every edge
// - strobe driven with data, preamble and postamble
// - after postamble the data lines float
// - read, write, stop or precharge truncates burst
// - chained read issued pairs-count cycles later
// - read accepted on any cycle after read
// - chained bursts join, earlier reads interrupt four/eight/sixteen
// - random reads interrupt bursts longer than two
// - burst stop has read latency
// - write waits for burst end or stop
// - burst two needs no stop before write
// - precharge truncation only without auto precharge
// - no bank command during precharge period
// - wide part: one strobe per byte lane
// - narrow part: lower and upper byte strobes
// - read latency two or three cycles
// - row open and activate delay before read
package lpddr_read_pkg;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_READ,
    CMD_WRITE,
    CMD_BST,
    CMD_PRE,
    CMD_ACT
  } cmd_t;

  localparam int BANKS  = 4;
  localparam int BANK_W = 2;

  // burst_length_setting codes
  localparam logic [1:0] BL_2  = 2'h0;
  localparam logic [1:0] BL_4  = 2'h1;
  localparam logic [1:0] BL_8  = 2'h2;
  localparam logic [1:0] BL_16 = 2'h3;

  // read_latency_cycles select: 0 gives 2, 1 gives 3
  localparam int CL_SHORT = 2;
  localparam int CL_LONG  = 3;

  localparam int SYS_PERIOD_NS  = 25;
  localparam int LINK_PERIOD_NS = 48;
  localparam int RAS_MIN_NS     = 42;
  localparam int RP_NS          = 18;
  localparam int RCD_NS         = 18;
  localparam int LINK_RST_CYCLES = 4;

  function automatic int cyclesUp(input int ns, input int per);
    int c;
    c = (ns + per - 1) / per;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RAS_MIN_LINK = cyclesUp(RAS_MIN_NS, LINK_PERIOD_NS);

  // data-element pairs in one burst, that is BL/2
  function automatic logic [3:0] pairsOf(input logic [1:0] bl);
    return 4'(1 << bl);
  endfunction

endpackage

// ### src/lpddr_link_if.sv
`timescale 1ns/1ps
interface lpddr_link_if
  import lpddr_read_pkg::*;
#(
  parameter int DQW  = 16,
  parameter int COLW = 10
);
  logic                  ck;
  logic                  linkRst;
  cmd_t                  cmd;
  logic [BANK_W-1:0]     bank;
  logic [COLW-1:0]       col;
  logic                  autoPre;
  logic [DQW-1:0]        dqOut;
  logic                  dqOe;
  logic [DQW/8-1:0]      dqsOut;
  logic [DQW/8-1:0]      dqsOe;
  wire  [DQW-1:0]        dq;
  wire  [DQW/8-1:0]      dqs;

  // released lines read as pulled low, the idle level of the strobe
  assign dq = dqOe ? dqOut : '0;

  genvar g;
  for (g = 0; g < DQW / 8; g++) begin : g_lane
    assign dqs[g] = dqsOe[g] ? dqsOut[g] : 1'b0;
  end

  modport dev (
    input  ck,
    input  linkRst,
    input  cmd,
    input  bank,
    input  col,
    input  autoPre,
    output dqOut,
    output dqOe,
    output dqsOut,
    output dqsOe
  );

  modport host (
    output ck,
    output linkRst,
    output cmd,
    output bank,
    output col,
    output autoPre,
    input  dq,
    input  dqs
  );
endinterface

// ### src/lpddr_read_device.sv
`timescale 1ns/1ps
module lpddr_read_device
  import lpddr_read_pkg::*;
#(
  parameter int DQW  = 16,
  parameter int COLW = 10
)(
  lpddr_link_if.dev                link,
  input  wire logic                clkEn,
  input  wire logic [1:0]          blSel,
  input  wire logic                clSel,
  output logic [BANK_W-1:0]        fetchBank,
  output logic [COLW-1:0]          fetchCol,
  input  wire logic [2*DQW-1:0]    fetchData,
  output logic [BANKS-1:0]         bankOpen,
  output logic [BANKS-1:0]         rowPrecharge,
  output logic                     bursting,
  output logic                     closedReadErr
);

  localparam int LANES = DQW / 8;

  if (DQW != 16 && DQW != 32) begin : g_bad_width
    $error("data width must be 16 or 32");
  end
  if (COLW < 5) begin : g_bad_col
    $error("column width too small for a 16-element burst");
  end

  typedef struct packed {
    logic              valid;
    cmd_t              cmd;
    logic [BANK_W-1:0] bank;
    logic [COLW-1:0]   col;
    logic              ap;
  } slot_t;

  logic              ck;
  logic              rst;
  slot_t             inCmd;
  slot_t             pipe0;
  slot_t             pipe1;
  slot_t             launch;
  slot_t             early;
  logic [3:0]        pairsLeft;
  logic [COLW-1:0]   curCol;
  logic [COLW-1:0]   burstMask;
  logic [COLW-1:0]   nextCol;
  logic [BANK_W-1:0] burstBank;
  logic              burstAp;
  logic              doRead;
  logic              doStop;
  logic              willOut;
  logic              earlyRead;
  logic              pairValid;
  logic [DQW-1:0]    dqRise;
  logic [DQW-1:0]    oddHold;
  logic [DQW-1:0]    dqFall;
  logic              dqOeReg;
  logic              dqsOeReg;

  // the link clock and link reset come from the controller
  assign ck  = link.ck;
  assign rst = link.linkRst;

  always_comb begin
    inCmd.valid = (link.cmd != CMD_NOP);
    inCmd.cmd   = link.cmd;
    inCmd.bank  = link.bank;
    inCmd.col   = link.col;
    inCmd.ap    = link.autoPre;
  end

  always_ff @(posedge ck) begin
    if (rst) begin
      pipe0 <= '0;
      pipe1 <= '0;
    end else if (clkEn) begin
      pipe0 <= inCmd;
      pipe1 <= pipe0;
    end
  end

  assign launch = clSel ? pipe1 : pipe0;
  assign early  = clSel ? pipe0 : inCmd;

  assign doRead    = launch.valid && (launch.cmd == CMD_READ);
  assign earlyRead = early.valid && (early.cmd == CMD_READ);

  always_comb begin
    doStop = 1'b0;
    if (launch.valid) begin
      unique case (launch.cmd)
        CMD_BST:   doStop = 1'b1;
        CMD_WRITE: doStop = 1'b1;
        // precharge cuts only a burst without auto precharge
        CMD_PRE:   doStop = (launch.bank == burstBank) && !burstAp;
        CMD_NOP,
        CMD_READ,
        CMD_ACT:   doStop = 1'b0;
        default:   doStop = 1'b0;
      endcase
    end
  end

  // burst wraps inside its own aligned block of columns
  assign burstMask = COLW'((32'(pairsOf(blSel)) << 1) - 32'd1);
  assign nextCol   = (curCol & ~burstMask) |
                     (COLW'(curCol + COLW'(2)) & burstMask);

  // a new read at launch always wins over the running burst
  assign willOut = doRead || (!doStop && pairsLeft != 4'h0);

  // start column first, then the burst order
  assign fetchCol  = doRead ? launch.col : nextCol;
  assign fetchBank = doRead ? launch.bank : burstBank;

  // reload on every launched read; with two pairs ending
  // exactly as the next starts the bursts simply join
  // random reads interrupt
  always_ff @(posedge ck) begin
    if (rst) begin
      pairsLeft <= 4'h0;
      curCol    <= '0;
      burstBank <= '0;
      burstAp   <= 1'b0;
      pairValid <= 1'b0;
      dqRise    <= '0;
      oddHold   <= '0;
    end else if (clkEn) begin
      pairValid <= willOut;
      if (willOut) begin
        dqRise  <= fetchData[DQW-1:0];
        oddHold <= fetchData[2*DQW-1:DQW];
        curCol  <= fetchCol;
      end
      if (doRead) begin
        pairsLeft <= pairsOf(blSel) - 4'h1;
        burstBank <= launch.bank;
        burstAp   <= launch.ap;
      end else if (willOut) begin
        pairsLeft <= pairsLeft - 4'h1;
      end else begin
        pairsLeft <= 4'h0;
        burstAp   <= 1'b0;
      end
    end
  end

  // second element of each pair leaves on the falling edge
  always_ff @(negedge ck) begin
    if (rst) begin
      dqFall <= '0;
    end else if (clkEn) begin
      dqFall <= oddHold;
    end
  end

  // preamble one cycle ahead of the first pair
  // drivers off once the postamble has passed
  always_ff @(posedge ck) begin
    if (rst) begin
      dqOeReg  <= 1'b0;
      dqsOeReg <= 1'b0;
    end else if (clkEn) begin
      dqOeReg  <= willOut;
      dqsOeReg <= willOut || earlyRead;
    end
  end

  // the clock steers the output mux, so strobe stays edge-aligned
  // with data; this is a behavioural double-rate output stage
  assign link.dqOut = ck ? dqRise : dqFall;
  assign link.dqOe  = dqOeReg;

  genvar ln;
  for (ln = 0; ln < LANES; ln++) begin : g_strobe
    // low in preamble and during the falling-edge element of every pair
    assign link.dqsOut[ln] = pairValid & ck;
    assign link.dqsOe[ln]  = dqsOeReg;
  end

  assign bursting = pairValid;

  logic [7:0] rasCnt  [BANKS];
  logic [3:0] apCnt   [BANKS];
  logic       apArmed [BANKS];
  logic [BANKS-1:0] badRead;

  genvar b;
  for (b = 0; b < BANKS; b++) begin : g_bank
    logic hit;
    assign hit = inCmd.valid && (inCmd.bank == BANK_W'(b));

    always_ff @(posedge ck) begin
      if (rst) begin
        bankOpen[b]     <= 1'b0;
        rowPrecharge[b] <= 1'b0;
        rasCnt[b]       <= 8'h00;
        apCnt[b]        <= 4'h0;
        apArmed[b]      <= 1'b0;
        badRead[b]      <= 1'b0;
      end else if (clkEn) begin
        rowPrecharge[b] <= 1'b0;
        badRead[b]      <= hit && inCmd.cmd == CMD_READ && !bankOpen[b];
        if (rasCnt[b] != 8'h00) begin
          rasCnt[b] <= rasCnt[b] - 8'h01;
        end
        if (hit && inCmd.cmd == CMD_ACT) begin
          bankOpen[b] <= 1'b1;
          rasCnt[b]   <= 8'(RAS_MIN_LINK);
        end else if (hit && inCmd.cmd == CMD_PRE && !apArmed[b]) begin
          bankOpen[b]     <= 1'b0;
          rowPrecharge[b] <= bankOpen[b];
        end else if (hit && inCmd.cmd == CMD_READ && inCmd.ap) begin
          apArmed[b] <= 1'b1;
          apCnt[b]   <= pairsOf(blSel);
        end else if (apArmed[b]) begin
          // precharge at burst/2 once active time is met
          if (apCnt[b] > 4'h1) begin
            apCnt[b] <= apCnt[b] - 4'h1;
          end else if (rasCnt[b] == 8'h00) begin
            apArmed[b]      <= 1'b0;
            bankOpen[b]     <= 1'b0;
            rowPrecharge[b] <= 1'b1;
          end
        end
      end
    end
  end

  // sticky: a read to a closed bank means the controller slipped
  always_ff @(posedge ck) begin
    if (rst) begin
      closedReadErr <= 1'b0;
    end else if (clkEn && badRead != '0) begin
      closedReadErr <= 1'b1;
    end
  end

endmodule

// ### src/lpddr_read_host.sv
`timescale 1ns/1ps
module lpddr_read_host
  import lpddr_read_pkg::*;
#(
  parameter int DQW  = 16,
  parameter int COLW = 10,
  parameter int DIV  = 2
)(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  lpddr_link_if.host               link,
  input  wire logic [1:0]          blSel,
  input  wire logic                clSel,
  input  wire logic                reqValid,
  output logic                     reqReady,
  input  wire cmd_t                reqCmd,
  input  wire logic [BANK_W-1:0]   reqBank,
  input  wire logic [COLW-1:0]     reqCol,
  input  wire logic                reqAutoPre,
  output logic                     rdValid,
  output logic [2*DQW-1:0]         rdData
);

  if (DIV < 2) begin : g_bad_div
    $error("divider below 2 leaves no time to capture an element");
  end

  localparam int LINK_NS  = 2 * DIV * SYS_PERIOD_NS;
  localparam int RP_LINK  = cyclesUp(RP_NS, LINK_NS);
  localparam int RCD_LINK = cyclesUp(RCD_NS, LINK_NS);

  logic [7:0]      divCnt;
  logic            ckOut;
  logic            slot;
  logic [2:0]      rstCnt;
  logic            linkRst;
  logic [4:0]      burstLeft;
  logic            burstAp;
  logic [BANK_W-1:0] burstBank;
  logic [BANKS-1:0] open;
  logic [7:0]      rpCnt  [BANKS];
  logic [7:0]      rcdCnt [BANKS];
  logic            legal;
  logic            take;
  logic [3:0]      pairs;
  logic [4:0]      clCyc;

  assign pairs = pairsOf(blSel);
  assign clCyc = clSel ? 5'(CL_LONG) : 5'(CL_SHORT);

  // commands change as the link clock falls, mid-cycle for the device
  assign slot = clkEn && (divCnt == 8'(DIV - 1)) && ckOut;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      divCnt <= 8'h00;
      ckOut  <= 1'b0;
    end else if (clkEn) begin
      if (divCnt == 8'(DIV - 1)) begin
        divCnt <= 8'h00;
        ckOut  <= !ckOut;
      end else begin
        divCnt <= divCnt + 8'h01;
      end
    end
  end

  // link reset is held over several link edges so the device sees it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rstCnt  <= 3'(LINK_RST_CYCLES);
      linkRst <= 1'b1;
    end else if (slot) begin
      if (rstCnt != 3'h0) begin
        rstCnt <= rstCnt - 3'h1;
      end
      linkRst <= (rstCnt > 3'h1);
    end
  end

  always_comb begin
    legal = 1'b0;
    unique case (reqCmd)
      CMD_NOP, CMD_BST: legal = 1'b1;
      CMD_READ: legal = open[reqBank] && rcdCnt[reqBank] == 8'h00;
      CMD_WRITE: legal = open[reqBank] && rcdCnt[reqBank] == 8'h00 &&
                         (burstLeft == 5'h00 || blSel == BL_2);
      CMD_PRE: legal = rpCnt[reqBank] == 8'h00 &&
                       !(burstAp && burstLeft != 5'h00 &&
                         burstBank == reqBank);
      CMD_ACT: legal = !open[reqBank] && rpCnt[reqBank] == 8'h00;
      default: legal = 1'b0;
    endcase
  end

  // one command per link cycle, held back until bank and burst timing allow it
  assign reqReady = slot && !linkRst && legal;
  assign take     = reqValid && reqReady;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.cmd     <= CMD_NOP;
      link.bank    <= '0;
      link.col     <= '0;
      link.autoPre <= 1'b0;
    end else if (slot) begin
      link.cmd     <= take ? reqCmd : CMD_NOP;
      link.bank    <= reqBank;
      link.col     <= reqCol;
      link.autoPre <= reqAutoPre;
    end
  end

  assign link.ck      = ckOut;
  assign link.linkRst = linkRst;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      burstLeft <= 5'h00;
      burstAp   <= 1'b0;
      burstBank <= '0;
    end else if (slot) begin
      if (take && reqCmd == CMD_READ) begin
        burstLeft <= 5'(pairs) + clCyc;
        burstAp   <= reqAutoPre;
        burstBank <= reqBank;
      end else if (take && reqCmd == CMD_BST && burstLeft > clCyc) begin
        burstLeft <= clCyc;
      end else if (burstLeft != 5'h00) begin
        burstLeft <= burstLeft - 5'h01;
      end
    end
  end

  genvar b;
  for (b = 0; b < BANKS; b++) begin : g_bank
    logic hit;
    assign hit = take && reqBank == BANK_W'(b);
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        open[b]   <= 1'b0;
        rpCnt[b]  <= 8'h00;
        rcdCnt[b] <= 8'h00;
      end else if (slot) begin
        if (rpCnt[b] != 8'h00) rpCnt[b] <= rpCnt[b] - 8'h01;
        if (rcdCnt[b] != 8'h00) rcdCnt[b] <= rcdCnt[b] - 8'h01;
        if (hit && reqCmd == CMD_ACT) begin
          open[b]   <= 1'b1;
          rcdCnt[b] <= 8'(RCD_LINK);
        end else if (hit && reqCmd == CMD_PRE) begin
          open[b]  <= 1'b0;
          rpCnt[b] <= 8'(RP_LINK);
        end else if (hit && reqCmd == CMD_READ && reqAutoPre) begin
          open[b]  <= 1'b0;
          rpCnt[b] <= 8'(RP_LINK) + 8'(pairs);
        end
      end
    end
  end

  logic [DQW-1:0] dqMeta;
  logic [DQW-1:0] dqSync;
  logic           dqsMeta;
  logic           dqsSync;
  logic           dqsLast;
  logic [DQW-1:0] evenHold;
  logic           dqsPin;

  // floating strobe reads as low, like a terminated idle line
  assign dqsPin = (link.dqs[0] === 1'b1);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dqMeta  <= '0;
      dqSync  <= '0;
      dqsMeta <= 1'b0;
      dqsSync <= 1'b0;
      dqsLast <= 1'b0;
    end else if (clkEn) begin
      dqMeta  <= link.dq;
      dqSync  <= dqMeta;
      dqsMeta <= dqsPin;
      dqsSync <= dqsMeta;
      dqsLast <= dqsSync;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evenHold <= '0;
      rdData   <= '0;
      rdValid  <= 1'b0;
    end else if (clkEn) begin
      rdValid <= 1'b0;
      if (dqsSync && !dqsLast) begin
        evenHold <= dqSync;
      end else if (!dqsSync && dqsLast) begin
        rdData  <= {dqSync, evenHold};
        rdValid <= 1'b1;
      end
    end
  end

endmodule

// ### testbench/lpddr_read_burst_control_sva.sv
`timescale 1ns/1ps
module lpddr_read_burst_control_sva
  import lpddr_read_pkg::*;
#(
  parameter int DQW = 16
)(
  input wire logic             ck,
  input wire logic             linkRst,
  input wire cmd_t             cmd,
  input wire logic             dqOe,
  input wire logic [DQW/8-1:0] dqsOe,
  input wire logic [DQW/8-1:0] dqsOut,
  input wire logic [1:0]       blSel,
  input wire logic             clSel
);
  logic [5:0] sinceRd;
  logic       clean;
  logic [5:0] cl;
  logic [5:0] pairs;

  assign cl    = clSel ? 6'(CL_LONG) : 6'(CL_SHORT);
  assign pairs = 6'(pairsOf(blSel));

  // saturates so an old read never looks recent again
  always_ff @(posedge ck) begin
    if (linkRst) sinceRd <= 6'h3F;
    else if (cmd == CMD_READ) sinceRd <= 6'h01;
    else if (sinceRd != 6'h3F) sinceRd <= sinceRd + 6'h01;
  end

  // any stop-type command voids the full-length expectation
  always_ff @(posedge ck) begin
    if (linkRst) clean <= 1'b0;
    else if (cmd == CMD_READ) clean <= 1'b1;
    else if (cmd inside {CMD_BST, CMD_PRE, CMD_WRITE}) clean <= 1'b0;
  end

  sequence s_fresh;
    cmd == CMD_READ && !dqOe && dqsOe == '0 &&
      $past(cmd) != CMD_READ && $past(cmd, 2) != CMD_READ;
  endsequence
  sequence s_pre;
    !dqOe ##1 (dqsOe == '1 && !dqOe) ##1 dqOe;
  endsequence

  property p_pre_long;
    @(posedge ck) disable iff (linkRst) s_fresh ##0 clSel |-> ##1 s_pre;
  endproperty
  property p_pre_short;
    @(posedge ck) disable iff (linkRst) s_fresh ##0 !clSel |-> s_pre;
  endproperty
  property p_strobe_low;
    @(posedge ck) disable iff (linkRst) (|dqsOe) |-> dqsOut == '0;
  endproperty
  property p_strobe_high;
    @(negedge ck) disable iff (linkRst)
      dqOe |-> (dqsOut == '1 && dqsOe == '1);
  endproperty
  property p_oe_pair;
    @(posedge ck) disable iff (linkRst) dqOe |-> dqsOe == '1;
  endproperty
  property p_span;
    @(posedge ck) disable iff (linkRst)
      (clean && sinceRd >= cl && sinceRd < cl + pairs) |-> dqOe;
  endproperty
  property p_end;
    @(posedge ck) disable iff (linkRst)
      (clean && sinceRd == cl + pairs) |-> (!dqOe && dqsOe == '0);
  endproperty
  property p_stop_long;
    @(posedge ck) disable iff (linkRst)
      (cmd == CMD_BST && clSel) |-> ##3 !dqOe;
  endproperty
  property p_stop_short;
    @(posedge ck) disable iff (linkRst)
      (cmd == CMD_BST && !clSel) |-> ##2 !dqOe;
  endproperty
  property p_write_gap;
    @(posedge ck) disable iff (linkRst)
      (cmd == CMD_WRITE && blSel != BL_2) |-> !dqOe;
  endproperty

  a_pre_long: assert property (p_pre_long)
    else $error("preamble wrong at latency three");
  a_pre_short: assert property (p_pre_short)
    else $error("preamble wrong at latency two");
  a_strobe_low: assert property (p_strobe_low)
    else $error("strobe not low in preamble or odd half");
  a_strobe_high: assert property (p_strobe_high)
    else $error("strobe not high with even element");
  a_oe_pair: assert property (p_oe_pair)
    else $error("data driven without strobe");
  a_span: assert property (p_span)
    else $error("data missing inside burst");
  a_end: assert property (p_end)
    else $error("bus not released after burst");
  a_stop_long: assert property (p_stop_long)
    else $error("stop latency wrong at three");
  a_stop_short: assert property (p_stop_short)
    else $error("stop latency wrong at two");
  a_write_gap: assert property (p_write_gap)
    else $error("write issued during read data");
endmodule

// ### testbench/lpddr_read_burst_control_tb.sv
`timescale 1ns/1ps
module lpddr_read_burst_control_tb;
  import lpddr_read_pkg::*;
  localparam int DQW  = 16;
  localparam int COLW = 10;

  logic              sys_clk;
  logic              rst;
  logic              reqValid;
  logic              reqReady;
  cmd_t              reqCmd;
  logic [1:0]        reqBank;
  logic [COLW-1:0]   reqCol;
  logic              reqAutoPre;
  logic              rdValid;
  logic [2*DQW-1:0]  rdData;
  logic [1:0]        blSel;
  logic              clSel;
  logic [1:0]        fetchBank;
  logic [COLW-1:0]   fetchCol;
  logic [2*DQW-1:0]  fetchData;
  logic [1:0]        faultBank;
  logic [COLW-1:0]   faultCol;
  logic [2*DQW-1:0]  faultData;
  logic [BANKS-1:0]  bankOpen;
  logic [BANKS-1:0]  rowPrecharge;
  logic              closedReadErr;
  logic              faultErr;
  logic              ck2Run;
  logic              taken;
  logic [2*DQW-1:0]  q[$];
  int                failCount;
  int                comparisons;
  int                k;

  lpddr_link_if #(.DQW(DQW), .COLW(COLW)) lpddr_link_if_inst ();
  lpddr_link_if #(.DQW(DQW), .COLW(COLW)) faultLink ();

  function automatic logic [DQW-1:0] pat(input logic [1:0] b,
                                         input logic [COLW-1:0] c);
    return {b, 4'h5, c};
  endfunction

  assign fetchData = {pat(fetchBank, fetchCol + 10'h001),
                      pat(fetchBank, fetchCol)};
  assign faultData = {pat(faultBank, faultCol + 10'h001),
                      pat(faultBank, faultCol)};

  lpddr_read_host #(.DQW(DQW), .COLW(COLW)) lpddr_read_host_inst (
    .sys_clk(sys_clk), .rst(rst), .clkEn(1'b1),
    .link(lpddr_link_if_inst), .blSel(blSel), .clSel(clSel),
    .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd),
    .reqBank(reqBank), .reqCol(reqCol), .reqAutoPre(reqAutoPre),
    .rdValid(rdValid), .rdData(rdData));

  lpddr_read_device #(.DQW(DQW), .COLW(COLW)) lpddr_read_device_inst (
    .link(lpddr_link_if_inst), .clkEn(1'b1), .blSel(blSel),
    .clSel(clSel), .fetchBank(fetchBank), .fetchCol(fetchCol),
    .fetchData(fetchData), .bankOpen(bankOpen),
    .rowPrecharge(rowPrecharge), .bursting(),
    .closedReadErr(closedReadErr));

  // driven by the bench alone so it can break the host's rules
  lpddr_read_device #(.DQW(DQW), .COLW(COLW)) faultDevice (
    .link(faultLink), .clkEn(1'b1), .blSel(blSel), .clSel(clSel),
    .fetchBank(faultBank), .fetchCol(faultCol), .fetchData(faultData),
    .bankOpen(), .rowPrecharge(), .bursting(),
    .closedReadErr(faultErr));

  lpddr_read_burst_control_sva #(.DQW(DQW))
    lpddr_read_burst_control_sva_inst (
    .ck(lpddr_link_if_inst.ck), .linkRst(lpddr_link_if_inst.linkRst),
    .cmd(lpddr_link_if_inst.cmd), .dqOe(lpddr_link_if_inst.dqOe),
    .dqsOe(lpddr_link_if_inst.dqsOe),
    .dqsOut(lpddr_link_if_inst.dqsOut), .blSel(blSel), .clSel(clSel));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // fault link clock stands still outside its one frame
  initial begin
    faultLink.ck = 1'b0;
    forever #24 faultLink.ck = ck2Run ? ~faultLink.ck : 1'b0;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (failCount == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // request is raised and left up; waits until a slot takes it or lim cycles pass
  task automatic issue(input cmd_t c, input logic [1:0] b,
                       input logic [COLW-1:0] col, input logic ap,
                       input int lim);
    @(negedge sys_clk);
    reqValid   = 1'b1;
    reqCmd     = c;
    reqBank    = b;
    reqCol     = col;
    reqAutoPre = ap;
    taken      = 1'b0;
    for (int i = 0; i < lim && !taken; i++) begin
      @(posedge sys_clk);
      taken = (reqReady === 1'b1);
    end
  endtask

  task automatic cmdOk(input cmd_t c, input logic [1:0] b,
                       input logic [COLW-1:0] col, input logic ap);
    issue(c, b, col, ap, 100);
    check("request accepted", 32'(taken), 32'h1);
  endtask

  task automatic expectPairs(input logic [1:0] b,
                             input logic [COLW-1:0] c, input int n);
    for (int j = 0; j < n; j++)
      q.push_back({pat(b, 10'(c + 2 * j + 1)), pat(b, 10'(c + 2 * j))});
  endtask

  task automatic mode(input logic [1:0] bl, input logic cl);
    @(negedge sys_clk);
    reqValid = 1'b0;
    blSel    = bl;
    clSel    = cl;
  endtask

  task automatic settle();
    @(negedge sys_clk);
    reqValid = 1'b0;
    repeat (80) @(posedge sys_clk);
    check("pairs outstanding", 32'(q.size()), 32'h0);
  endtask

  always @(posedge sys_clk) begin
    if (rdValid === 1'b1) begin
      if (q.size() == 0) check("unexpected pair", rdData, 32'h0);
      else check("rdData", rdData, q.pop_front());
    end
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    failCount++;
    results();
  end

  initial begin
    rst = 1'b1; reqValid = 1'b0; reqCmd = CMD_NOP; reqBank = 2'h0;
    reqCol = 10'h000; reqAutoPre = 1'b0; blSel = BL_4; clSel = 1'b1;
    ck2Run = 1'b0; faultLink.linkRst = 1'b1; faultLink.cmd = CMD_NOP;
    faultLink.bank = 2'h0; faultLink.col = 10'h000;
    faultLink.autoPre = 1'b0; failCount = 0; comparisons = 0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    cmdOk(CMD_ACT, 2'h0, 10'h000, 1'b0);
    cmdOk(CMD_ACT, 2'h1, 10'h000, 1'b0);
    // every latency with every burst length
    for (int cl = 0; cl < 2; cl++) begin
      for (int bl = 0; bl < 4; bl++) begin
        mode(2'(bl), cl[0]);
        expectPairs(2'h0, 10'h040, 1 << bl);
        cmdOk(CMD_READ, 2'h0, 10'h040, 1'b0);
        settle();
      end
    end
    mode(BL_4, 1'b1);
    expectPairs(2'h0, 10'h020, 2);
    expectPairs(2'h1, 10'h080, 2);
    cmdOk(CMD_READ, 2'h0, 10'h020, 1'b0);
    // two link cycles apart so the four-beat bursts join
    mode(BL_4, 1'b1);
    repeat (4) @(posedge sys_clk);
    cmdOk(CMD_READ, 2'h1, 10'h080, 1'b0);
    settle();
    mode(BL_8, 1'b1);
    expectPairs(2'h0, 10'h008, 1);
    expectPairs(2'h1, 10'h010, 4);
    cmdOk(CMD_READ, 2'h0, 10'h008, 1'b0);
    cmdOk(CMD_READ, 2'h1, 10'h010, 1'b0);
    settle();
    expectPairs(2'h1, 10'h030, 1);
    cmdOk(CMD_READ, 2'h1, 10'h030, 1'b0);
    cmdOk(CMD_BST, 2'h1, 10'h000, 1'b0);
    settle();
    mode(BL_8, 1'b0);
    expectPairs(2'h1, 10'h050, 1);
    cmdOk(CMD_READ, 2'h1, 10'h050, 1'b0);
    cmdOk(CMD_BST, 2'h1, 10'h000, 1'b0);
    settle();
    mode(BL_16, 1'b0);
    expectPairs(2'h1, 10'h020, 1);
    cmdOk(CMD_READ, 2'h1, 10'h020, 1'b0);
    cmdOk(CMD_PRE, 2'h1, 10'h000, 1'b0);
    settle();
    check("bank1 open", 32'(bankOpen[1]), 32'h0);
    issue(CMD_READ, 2'h1, 10'h000, 1'b0, 40);
    check("closed bank read", 32'(taken), 32'h0);
    mode(BL_4, 1'b1);
    expectPairs(2'h0, 10'h060, 2);
    cmdOk(CMD_READ, 2'h0, 10'h060, 1'b0);
    cmdOk(CMD_WRITE, 2'h0, 10'h000, 1'b0);
    settle();
    mode(BL_2, 1'b1);
    expectPairs(2'h0, 10'h002, 1);
    cmdOk(CMD_READ, 2'h0, 10'h002, 1'b0);
    cmdOk(CMD_WRITE, 2'h0, 10'h000, 1'b0);
    settle();
    mode(BL_4, 1'b1);
    expectPairs(2'h0, 10'h044, 2);
    cmdOk(CMD_READ, 2'h0, 10'h044, 1'b1);
    k = 0;
    do begin
      // falling edge: the pulse is settled, not racing its launch
      @(negedge lpddr_link_if_inst.ck);
      k++;
    end while (rowPrecharge[0] !== 1'b1 && k < 12);
    check("precharge delay", 32'(k), 32'(pairsOf(BL_4)) + 32'h2);
    settle();
    check("bank0 open", 32'(bankOpen[0]), 32'h0);
    check("closedReadErr", 32'(closedReadErr), 32'h0);
    // fault link: a read sent to a bank never opened
    ck2Run = 1'b1;
    repeat (3) @(posedge faultLink.ck);
    @(negedge faultLink.ck) faultLink.linkRst = 1'b0;
    @(negedge faultLink.ck);
    faultLink.cmd  = CMD_READ;
    faultLink.bank = 2'h1;
    @(negedge faultLink.ck) faultLink.cmd = CMD_NOP;
    repeat (3) @(posedge faultLink.ck);
    check("fault closedReadErr", 32'(faultErr), 32'h1);
    ck2Run = 1'b0;
    results();
  end
endmodule
